// ### hw/dcs_defs.svh
`ifndef DCS_DEFS_SVH
`define DCS_DEFS_SVH

// ============================================================
// clock select register layout
`define SEL_SRC_MSB 3
`define SEL_SRC_LSB 0
`define SEL_SUT_MSB 5
`define SEL_SUT_LSB 4
`define SEL_CLOCK_OUT_ENABLE_BIT_BIT 6

// ============================================================
// command register
`define CMD_CCE_BIT 7
`define CMD_DISABLE 8'h01
`define CMD_ENABLE 8'h02
`define CMD_READY 8'h03
`define CMD_SWITCH 8'h04
`define CMD_RECOVER 8'h05
`define CMD_WD_ARL 8'h06
`define CCE_WINDOW 3'h4

// one-hot command decode positions
`define X_DIS 0
`define X_EN 1
`define X_RDY 2
`define X_SW 3
`define X_REC 4
`define X_ARL 5

// ============================================================
// source codes and indices
`define CODE_EXT 4'h0
`define CODE_RC 4'h2
`define CODE_WD 4'h3
`define CODE_LF 4'h6
`define NSRC 5
`define IDX_RC 3'h0
`define IDX_WD 3'h1
`define IDX_EXT 3'h2
`define IDX_LF 3'h3
`define IDX_XTAL 3'h4
`define IDX_NONE 3'h7
`define EXT_MASK 5'h1c

// ============================================================
// timing
`define CK_6 16'h0006
`define CK_14 16'h000e
`define CK_258 16'h0102
`define CK_1K 16'h0400
`define CK_16K 16'h4000
`define CK_32K 16'h8000
`define SWITCH_EDGES 2'h2
`define T_CLK_NS 5
`define T_4P1MS_NS 4100000
`define T_4MS_NS 4000000
`define T_65MS_NS 65000000

`endif

// ### hw/dcs_pkg.sv
package dcs_pkg;
  typedef logic [2:0] src_idx_t;
  typedef enum logic [1:0] {BT_SYNC, BT_MS, BT_CK, BT_RUN} boot_e;
  typedef enum logic [1:0] {SW_IDLE, SW_DROP, SW_TAKE} sw_e;
  typedef enum logic [1:0] {MS_NONE, MS_4P1, MS_65, MS_4} ms_sel_e;
endpackage : dcs_pkg

// ### hw/source_edge_counter.sv
`timescale 1ns/10ps
`include "dcs_defs.svh"
module source_edge_counter (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`NSRC-1:0] src_clk,
  input wire dcs_pkg::src_idx_t sel,
  input wire logic start,
  input wire logic [15:0] limit,
  output logic [`NSRC-1:0] src_edge_r,
  output logic done_r
);
  import dcs_pkg::*;

  logic [`NSRC-1:0] s1_r, s2_r, s3_r, edge_nxt;
  logic run_r, run_nxt, done_nxt;
  logic [15:0] cnt_r, cnt_nxt, lim_r, lim_nxt;
  src_idx_t sel_r, sel_nxt;

  // ============================================================
  // oscillation cycle count
  // source clocks are far slower than clk, so sampling catches each cycle
  always_comb begin
    edge_nxt = s2_r & ~s3_r;
    run_nxt = run_r;
    cnt_nxt = cnt_r;
    lim_nxt = lim_r;
    sel_nxt = sel_r;
    done_nxt = 1'b0;
    if (start) begin
      run_nxt = 1'b1;
      cnt_nxt = 16'h0000;
      lim_nxt = limit;
      sel_nxt = sel;
    end else if (run_r && edge_nxt[sel_r]) begin
      cnt_nxt = cnt_r + 16'h0001;
      if (cnt_nxt >= lim_r) begin
        run_nxt = 1'b0;
        done_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      src_edge_r <= '0;
      run_r <= 1'b0;
      cnt_r <= 16'h0000;
      lim_r <= 16'h0000;
      sel_r <= `IDX_RC;
      done_r <= 1'b0;
    end else begin
      s1_r <= src_clk;
      s2_r <= s1_r;
      s3_r <= s2_r;
      src_edge_r <= edge_nxt;
      run_r <= run_nxt;
      cnt_r <= cnt_nxt;
      lim_r <= lim_nxt;
      sel_r <= sel_nxt;
      done_r <= done_nxt;
    end
  end
endmodule : source_edge_counter

// ### hw/dynamic_clock_source_switch.sv
`timescale 1ns/10ps
`include "dcs_defs.svh"
// Operation
// - low-frequency crystal start-up 1024CK or 32768CK plus 4.1ms or 65ms
// - external clock 6CK from power-down; 14CK plus 4.1ms or 65ms at reset
// - external clock code 00 adds 4ms at reset only if reset pin disabled
// - async timer may start the low-frequency crystal when the crystal and external clock are off
// - async timer may enable external clock when no crystal runs
// - clock out driven when enabled and no crystal used, never during reset
// - clock out carries the divided system clock
// - sources enable, disable and switch without system clock glitches
// - command register changes only through the protected write procedure
// - change-enable write, then command code 01,02,03,04,05 or 06
// - only one command operation launches at a time
// - reset copies fuse settings into the clock select register
// - enable turns on selected source and starts the readiness count
// - disable turns off selected source unless it drives system clock
// - each source latches its own enable; several may run together
// - readiness count clears flag at start, sets it at the limit
// - recover writes current system source code into the source field
// - switch may take the system clock from any of five sources
// - only one of three external sources enabled; timer shares them
module dynamic_clock_source_switch #(
  parameter int unsigned DLY_4P1MS_CYC =
    (`T_4P1MS_NS + `T_CLK_NS - 1) / `T_CLK_NS,
  parameter int unsigned DLY_4MS_CYC =
    (`T_4MS_NS + `T_CLK_NS - 1) / `T_CLK_NS,
  parameter int unsigned DLY_65MS_CYC =
    (`T_65MS_NS + `T_CLK_NS - 1) / `T_CLK_NS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] clock_select_fuses,
  input wire logic [1:0] startup_fuses,
  input wire logic clock_out_fuse,
  input wire logic reset_pin_disable_fuse,
  input wire logic [`NSRC-1:0] source_clocks,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_wdata,
  input wire logic sel_wr,
  input wire logic [7:0] sel_wdata,
  input wire logic timer_lf_request,
  input wire logic timer_ext_request,
  input wire logic wake_request,
  input wire logic prescaled_clk,
  output logic [7:0] clock_select_register,
  output logic source_ready_flag,
  output logic [3:0] system_source_code,
  output logic [`NSRC-1:0] source_enables,
  output logic [`NSRC-1:0] source_gates,
  output logic core_run,
  output logic wd_auto_reload,
  output logic clock_out_pin,
  output logic clock_out_pin_oe
);
  import dcs_pkg::*;

  // ============================================================
  // decode helpers
  function automatic src_idx_t src_index(input logic [3:0] code);
    src_idx_t r;
    r = `IDX_NONE;
    if (code[3]) r = `IDX_XTAL;
    else if (code == `CODE_RC) r = `IDX_RC;
    else if (code == `CODE_WD) r = `IDX_WD;
    else if (code == `CODE_EXT) r = `IDX_EXT;
    else if (code == `CODE_LF) r = `IDX_LF;
    return r;
  endfunction : src_index

  function automatic logic [`NSRC-1:0] onehot(input src_idx_t i);
    logic [`NSRC-1:0] r;
    r = '0;
    if (i != `IDX_NONE) r[i] = 1'b1;
    return r;
  endfunction : onehot

  // readiness and power-down start-up length in source cycles
  function automatic logic [15:0] ready_limit(input src_idx_t i,
                                              input logic [1:0] sut,
                                              input logic c0);
    logic [15:0] r;
    r = `CK_6;
    if (i == `IDX_LF) r = (sut == 2'h2) ? `CK_32K : `CK_1K;
    else if (i == `IDX_XTAL && !c0) r = sut[1] ? `CK_1K : `CK_258;
    else if (i == `IDX_XTAL) r = (sut == 2'h0) ? `CK_1K : `CK_16K;
    return r;
  endfunction : ready_limit

  function automatic ms_sel_e ms_select(input src_idx_t i,
                                        input logic [1:0] sut,
                                        input logic c0, input logic rdis);
    ms_sel_e r;
    r = MS_65;
    if (i == `IDX_XTAL) begin
      unique case ({c0, sut})
        3'h0, 3'h3, 3'h6: r = MS_4P1;
        3'h2, 3'h5: r = MS_NONE;
        default: r = MS_65;
      endcase
    end else if (i == `IDX_LF) begin
      r = (sut == 2'h0) ? MS_4P1 : MS_65;
    end else if (sut == 2'h0) begin
      r = (i == `IDX_EXT && rdis) ? MS_4 : MS_NONE;
    end else if (sut == 2'h1) begin
      r = MS_4P1;
    end
    return r;
  endfunction : ms_select

  function automatic logic [23:0] ms_cycles(input ms_sel_e m);
    logic [23:0] r;
    r = 24'h000000;
    if (m == MS_4P1) r = 24'(DLY_4P1MS_CYC);
    else if (m == MS_65) r = 24'(DLY_65MS_CYC);
    else if (m == MS_4) r = 24'(DLY_4MS_CYC);
    return r;
  endfunction : ms_cycles

  function automatic logic [5:0] cmd_decode(input logic [7:0] d);
    logic [5:0] r;
    r = 6'h00;
    unique case (d)
      `CMD_DISABLE: r[`X_DIS] = 1'b1;
      `CMD_ENABLE: r[`X_EN] = 1'b1;
      `CMD_READY: r[`X_RDY] = 1'b1;
      `CMD_SWITCH: r[`X_SW] = 1'b1;
      `CMD_RECOVER: r[`X_REC] = 1'b1;
      `CMD_WD_ARL: r[`X_ARL] = 1'b1;
      default: r = 6'h00;
    endcase
    return r;
  endfunction : cmd_decode

  // ============================================================
  // state
  logic [7:0] fz1_r, fz2_r, fz1_nxt, fz2_nxt;
  boot_e boot_r, boot_nxt;
  logic [23:0] btcnt_r, bt_nxt;
  logic [7:0] sel_nxt;
  logic [2:0] cce_r, cce_nxt;
  logic [`NSRC-1:0] en_r, en_nxt, osc_nxt, gate_nxt;
  src_idx_t sys_idx_r, sys_nxt, sw_new_r, swn_nxt, cidx, fidx;
  logic [3:0] code_nxt, sw_code_r, swcode_nxt;
  sw_e sw_r, sw_nxt;
  logic [1:0] swc_r, swc_nxt;
  logic rdy_nxt, wd_nxt, waking_r, wake_nxt, run_nxt, pin_nxt, oe_nxt;
  logic lf_share, ext_share, ext_clash;
  logic [5:0] exec;
  logic cnt_start, cnt_done;
  src_idx_t cnt_sel;
  logic [15:0] cnt_lim;
  logic [`NSRC-1:0] src_edge;

  source_edge_counter source_edge_counter_i (
    .clk(clk),
    .rst(rst),
    .src_clk(source_clocks),
    .sel(cnt_sel),
    .start(cnt_start),
    .limit(cnt_lim),
    .src_edge_r(src_edge),
    .done_r(cnt_done)
  );

  // ============================================================
  // control
  always_comb begin
    fz1_nxt = {reset_pin_disable_fuse, clock_out_fuse, startup_fuses,
               clock_select_fuses};
    fz2_nxt = fz1_r;
    fidx = src_index(fz2_r[3:0]);
    if (fidx == `IDX_NONE) fidx = `IDX_RC;
    cidx = src_index(clock_select_register[`SEL_SRC_MSB:`SEL_SRC_LSB]);
    ext_clash = |(`EXT_MASK & onehot(cidx)) &&
                |(source_enables & `EXT_MASK & ~onehot(cidx));
    boot_nxt = boot_r;
    bt_nxt = btcnt_r;
    sel_nxt = clock_select_register;
    cce_nxt = cce_r;
    en_nxt = en_r;
    sys_nxt = sys_idx_r;
    code_nxt = system_source_code;
    sw_nxt = sw_r;
    swn_nxt = sw_new_r;
    swcode_nxt = sw_code_r;
    swc_nxt = swc_r;
    gate_nxt = source_gates;
    wd_nxt = wd_auto_reload;
    wake_nxt = waking_r;
    exec = 6'h00;
    cnt_start = 1'b0;
    cnt_sel = sys_idx_r;
    cnt_lim = ready_limit(sys_idx_r,
                          clock_select_register[`SEL_SUT_MSB:`SEL_SUT_LSB],
                          clock_select_register[0]);
    unique case (boot_r)
      BT_SYNC: begin
        bt_nxt = btcnt_r + 24'h000001;
        if (btcnt_r == 24'h000002) begin
          sel_nxt = {1'b0, ~fz2_r[6], fz2_r[5:0]};
          sys_nxt = fidx;
          code_nxt = (src_index(fz2_r[3:0]) == `IDX_NONE) ? `CODE_RC
                                                          : fz2_r[3:0];
          en_nxt = onehot(fidx);
          bt_nxt = ms_cycles(ms_select(fidx, fz2_r[5:4], fz2_r[0],
                                       fz2_r[7]));
          boot_nxt = BT_MS;
        end
      end
      BT_MS: begin
        if (btcnt_r <= 24'h000001) begin
          boot_nxt = BT_CK;
          cnt_start = 1'b1;
          // slow crystals need their full start-up on top of the delay
          if (sys_idx_r != `IDX_LF && sys_idx_r != `IDX_XTAL)
            cnt_lim = `CK_14;
        end else begin
          bt_nxt = btcnt_r - 24'h000001;
        end
      end
      BT_CK: begin
        if (cnt_done) begin
          boot_nxt = BT_RUN;
          gate_nxt = onehot(sys_idx_r);
        end
      end
      BT_RUN: begin
        if (cce_r != 3'h0) cce_nxt = cce_r - 3'h1;
        if (cmd_wr && cmd_wdata[`CMD_CCE_BIT]) begin
          cce_nxt = `CCE_WINDOW;
        end else if (cmd_wr && cce_r != 3'h0) begin
          cce_nxt = 3'h0;
          // a switch in flight owns the source gates
          if (sw_r == SW_IDLE) exec = cmd_decode(cmd_wdata);
        end
        if (cidx != `IDX_NONE) begin
          if (exec[`X_EN] && !ext_clash) begin
            en_nxt[cidx] = 1'b1;
          end
          // a refused enable keeps the last ready verdict
          if ((exec[`X_EN] && !ext_clash) || exec[`X_RDY]) begin
            cnt_start = 1'b1;
            cnt_sel = cidx;
            cnt_lim = ready_limit(cidx,
              clock_select_register[`SEL_SUT_MSB:`SEL_SUT_LSB],
              clock_select_register[0]);
          end
          if (exec[`X_DIS] && cidx != sys_idx_r)
            en_nxt[cidx] = 1'b0;
          if (exec[`X_SW] && source_enables[cidx] && cidx != sys_idx_r) begin
            sw_nxt = SW_DROP;
            swn_nxt = cidx;
            swcode_nxt = clock_select_register[`SEL_SRC_MSB:`SEL_SRC_LSB];
            swc_nxt = 2'h0;
            gate_nxt = '0;
          end
        end
        if (exec[`X_REC])
          sel_nxt[`SEL_SRC_MSB:`SEL_SRC_LSB] = system_source_code;
        else if (sel_wr)
          sel_nxt = {1'b0, sel_wdata[6:0]};
        if (exec[`X_ARL]) wd_nxt = 1'b1;
        if (wake_request && !waking_r && !cnt_start && sw_r == SW_IDLE) begin
          wake_nxt = 1'b1;
          cnt_start = 1'b1;
        end else if (waking_r && cnt_done) begin
          wake_nxt = 1'b0;
        end
        // a dead source stalls the switch and blocks every command, recover included
        unique case (sw_r)
          SW_IDLE: ;
          SW_DROP: begin
            if (src_edge[sys_idx_r]) begin
              swc_nxt = swc_r + 2'h1;
              if (swc_nxt == `SWITCH_EDGES) begin
                sw_nxt = SW_TAKE;
                swc_nxt = 2'h0;
              end
            end
          end
          SW_TAKE: begin
            if (src_edge[sw_new_r]) begin
              swc_nxt = swc_r + 2'h1;
              if (swc_nxt == `SWITCH_EDGES) begin
                sw_nxt = SW_IDLE;
                gate_nxt = onehot(sw_new_r);
                sys_nxt = sw_new_r;
                code_nxt = sw_code_r;
              end
            end
          end
          default: sw_nxt = SW_IDLE;
        endcase
      end
    endcase
    // a restart wins: the new count has not reached its limit
    if (cnt_start) rdy_nxt = 1'b0;
    else if (cnt_done) rdy_nxt = 1'b1;
    else rdy_nxt = source_ready_flag;
    lf_share = timer_lf_request && !en_nxt[`IDX_XTAL] &&
               !en_nxt[`IDX_EXT];
    ext_share = timer_ext_request && !timer_lf_request &&
                !en_nxt[`IDX_XTAL] && !en_nxt[`IDX_LF];
    osc_nxt = en_nxt;
    osc_nxt[`IDX_LF] = en_nxt[`IDX_LF] | lf_share;
    osc_nxt[`IDX_EXT] = en_nxt[`IDX_EXT] | ext_share;
    run_nxt = (boot_nxt == BT_RUN) && !wake_nxt;
    oe_nxt = clock_select_register[`SEL_CLOCK_OUT_ENABLE_BIT_BIT] && core_run &&
             !source_enables[`IDX_XTAL] &&
             !source_enables[`IDX_LF];
    pin_nxt = oe_nxt && prescaled_clk;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fz1_r <= 8'h00;
      fz2_r <= 8'h00;
      boot_r <= BT_SYNC;
      btcnt_r <= 24'h000000;
      clock_select_register <= 8'h00;
      cce_r <= 3'h0;
      en_r <= '0;
      source_enables <= '0;
      source_gates <= '0;
      sys_idx_r <= `IDX_RC;
      system_source_code <= `CODE_RC;
      sw_r <= SW_IDLE;
      sw_new_r <= `IDX_RC;
      sw_code_r <= `CODE_RC;
      swc_r <= 2'h0;
      source_ready_flag <= 1'b0;
      wd_auto_reload <= 1'b0;
      waking_r <= 1'b0;
      core_run <= 1'b0;
      clock_out_pin <= 1'b0;
      clock_out_pin_oe <= 1'b0;
    end else begin
      fz1_r <= fz1_nxt;
      fz2_r <= fz2_nxt;
      boot_r <= boot_nxt;
      btcnt_r <= bt_nxt;
      clock_select_register <= sel_nxt;
      cce_r <= cce_nxt;
      en_r <= en_nxt;
      source_enables <= osc_nxt;
      source_gates <= gate_nxt;
      sys_idx_r <= sys_nxt;
      system_source_code <= code_nxt;
      sw_r <= sw_nxt;
      sw_new_r <= swn_nxt;
      sw_code_r <= swcode_nxt;
      swc_r <= swc_nxt;
      source_ready_flag <= rdy_nxt;
      wd_auto_reload <= wd_nxt;
      waking_r <= wake_nxt;
      core_run <= run_nxt;
      clock_out_pin <= pin_nxt;
      clock_out_pin_oe <= oe_nxt;
    end
  end

  // ============================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_closed_ignored;
    (boot_r == BT_RUN && cmd_wr && cce_r == 3'h0 &&
     !cmd_wdata[`CMD_CCE_BIT] && !sel_wr)
      |=> $stable(clock_select_register) && $stable(en_r);
  endproperty
  a_closed_ignored: assert property (p_closed_ignored)
    else $error("command taken without change enable");

  property p_cce_cleared;
    (cce_r != 3'h0 && cmd_wr && !cmd_wdata[`CMD_CCE_BIT]) |=> cce_r == 3'h0;
  endproperty
  a_cce_cleared: assert property (p_cce_cleared)
    else $error("change enable not cleared after command");

  property p_one_cmd;
    $onehot0(exec);
  endproperty
  a_one_cmd: assert property (p_one_cmd)
    else $error("more than one command launched");

  property p_dis_sys;
    (exec[`X_DIS] && cidx == sys_idx_r) |=> en_r == $past(en_r);
  endproperty
  a_dis_sys: assert property (p_dis_sys)
    else $error("system source was disabled");

  property p_ready_count;
    cnt_start |=> !source_ready_flag ##0 (!cnt_done)[*1];
  endproperty
  a_ready_count: assert property (p_ready_count)
    else $error("ready flag not cleared at count start");

  property p_recover;
    exec[`X_REC] |=>
      clock_select_register[3:0] == $past(system_source_code);
  endproperty
  a_recover: assert property (p_recover)
    else $error("recover returned wrong source code");

  property p_ext_excl;
    $onehot0(source_enables & `EXT_MASK);
  endproperty
  a_ext_excl: assert property (p_ext_excl)
    else $error("two external sources enabled");

  property p_gate_break;
    sw_r != SW_IDLE |-> source_gates == '0 && $onehot0($past(source_gates));
  endproperty
  a_gate_break: assert property (p_gate_break)
    else $error("gate open during switch");

  property p_clock_out_enable_bit_reset;
    !core_run |=> !clock_out_pin_oe;
  endproperty
  a_clock_out_enable_bit_reset: assert property (p_clock_out_enable_bit_reset)
    else $error("clock out driven while held");

  property p_clock_out_enable_bit_div;
    clock_out_pin_oe |-> clock_out_pin == $past(prescaled_clk);
  endproperty
  a_clock_out_enable_bit_div: assert property (p_clock_out_enable_bit_div)
    else $error("clock out not the divided clock");

  property p_fuse_copy;
    (boot_r == BT_SYNC && btcnt_r == 24'h000002) |=>
      clock_select_register[5:0] == $past(fz2_r[5:0]) &&
      clock_select_register[6] == !$past(fz2_r[6]);
  endproperty
  a_fuse_copy: assert property (p_fuse_copy)
    else $error("fuse copy wrong");
endmodule : dynamic_clock_source_switch

// ### bench/dynamic_clock_source_switch_test.sv
`timescale 1ns/10ps
// ============================================================
// stimulus and checks
module dynamic_clock_source_switch_test;
  logic clk, rst, clock_out_fuse, reset_pin_disable_fuse;
  logic [3:0] clock_select_fuses, system_source_code;
  logic [1:0] startup_fuses;
  logic [4:0] source_clocks, source_enables, source_gates;
  logic cmd_wr, sel_wr, timer_lf_request, timer_ext_request;
  logic wake_request, prescaled_clk, source_ready_flag, core_run;
  logic wd_auto_reload, clock_out_pin, clock_out_pin_oe;
  logic [7:0] cmd_wdata, sel_wdata, clock_select_register;
  int error_cnt, check_count, n0, n1, n2;

  dynamic_clock_source_switch #(
    .DLY_4P1MS_CYC(20), .DLY_4MS_CYC(18), .DLY_65MS_CYC(40)
  ) dynamic_clock_source_switch_i (
    .clk, .rst, .clock_select_fuses, .startup_fuses, .clock_out_fuse,
    .reset_pin_disable_fuse, .source_clocks, .cmd_wr, .cmd_wdata,
    .sel_wr, .sel_wdata, .timer_lf_request, .timer_ext_request,
    .wake_request, .prescaled_clk, .clock_select_register,
    .source_ready_flag, .system_source_code, .source_enables,
    .source_gates, .core_run, .wd_auto_reload, .clock_out_pin,
    .clock_out_pin_oe
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // distinct slow periods so oscillator edges drift against each other
  for (genvar g = 0; g < 5; g++) begin : osc
    initial begin
      source_clocks[g] = 1'b0;
      forever #(20 + 5 * g) source_clocks[g] = ~source_clocks[g];
    end
  end

  // ============================================================
  // tasks
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(logic s, logic [7:0] v);
    @(negedge clk);
    sel_wr = s;
    cmd_wr = !s;
    sel_wdata = v;
    cmd_wdata = v;
    @(negedge clk);
    sel_wr = 1'b0;
    cmd_wr = 1'b0;
  endtask : wr

  task automatic cmd(logic [7:0] v);
    @(negedge clk);
    cmd_wr = 1'b1;
    cmd_wdata = 8'h80;
    @(negedge clk);
    cmd_wdata = v;
    @(negedge clk);
    cmd_wr = 1'b0;
  endtask : cmd

  task automatic en_is(logic [4:0] e, int n);
    for (int i = 0; i < n && source_enables !== e; i++) @(negedge clk);
    check("enables", {3'h0, source_enables}, {3'h0, e});
  endtask : en_is

  task automatic wait_ready();
    for (int i = 0; i < 400 && source_ready_flag !== 1'b1; i++)
      @(negedge clk);
    check("ready", {7'h0, source_ready_flag}, 8'h01);
  endtask : wait_ready

  task automatic boot(logic [3:0] c, logic [1:0] s, logic f, logic r,
                      output int n);
    rst = 1'b1;
    clock_select_fuses = c;
    startup_fuses = s;
    clock_out_fuse = f;
    reset_pin_disable_fuse = r;
    repeat (16) @(negedge clk);
    check("oe in reset", {7'h0, clock_out_pin_oe}, 8'h00);
    rst = 1'b0;
    for (n = 0; n < 3000 && core_run !== 1'b1; n++) @(negedge clk);
    check("select", clock_select_register, {1'b0, ~f, s, c});
    repeat (2) @(negedge clk);
    check("oe", {7'h0, clock_out_pin_oe}, {7'h0, ~f});
  endtask : boot

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  initial begin
    #100us;
    error_cnt++;
    close_out();
  end

  // ============================================================
  // main sequence
  initial begin
    error_cnt = 0;
    check_count = 0;
    {cmd_wr, sel_wr, timer_lf_request, timer_ext_request} = 4'h0;
    {wake_request, prescaled_clk, cmd_wdata, sel_wdata} = 18'h00000;
    boot(4'h2, 2'h0, 1'b0, 1'b0, n0);
    check("code", {4'h0, system_source_code}, 8'h02);
    for (int i = 0; i < 2; i++) begin
      prescaled_clk = (i == 0);
      @(negedge clk);
      check("pin", {7'h0, clock_out_pin}, {7'h0, prescaled_clk});
    end
    $display("test boot done");
    wr(1'b1, 8'h43);
    wr(1'b0, 8'h02);
    en_is(5'h01, 0);
    cmd(8'h02);
    en_is(5'h03, 0);
    check("ready", {7'h0, source_ready_flag}, 8'h00);
    wait_ready();
    cmd(8'h04);
    check("gates", {3'h0, source_gates}, 8'h00);
    for (int i = 0; i < 400 && system_source_code !== 4'h3; i++)
      @(negedge clk);
    check("gates", {3'h0, source_gates}, 8'h02);
    wr(1'b1, 8'h56);
    cmd(8'h05);
    check("select", clock_select_register, 8'h53);
    $display("test switch done");
    wr(1'b1, 8'h43);
    cmd(8'h01);
    en_is(5'h03, 0);
    wr(1'b1, 8'h42);
    wr(1'b0, 8'h80);
    repeat (6) @(negedge clk);
    wr(1'b0, 8'h01);
    en_is(5'h03, 0);
    cmd(8'h01);
    en_is(5'h02, 0);
    cmd(8'h07);
    en_is(5'h02, 0);
    cmd(8'h06);
    check("reload", {7'h0, wd_auto_reload}, 8'h01);
    $display("test command done");
    wr(1'b1, 8'h40);
    cmd(8'h02);
    en_is(5'h06, 0);
    wait_ready();
    cmd(8'h03);
    check("ready", {7'h0, source_ready_flag}, 8'h00);
    wait_ready();
    wr(1'b1, 8'h46);
    cmd(8'h02);
    en_is(5'h06, 0);
    check("kept", {7'h0, source_ready_flag}, 8'h01);
    timer_lf_request = 1'b1;
    repeat (4) @(negedge clk);
    en_is(5'h06, 0);
    wr(1'b1, 8'h40);
    cmd(8'h01);
    en_is(5'h0a, 8);
    @(negedge clk);
    check("oe", {7'h0, clock_out_pin_oe}, 8'h00);
    timer_lf_request = 1'b0;
    timer_ext_request = 1'b1;
    en_is(5'h06, 8);
    timer_ext_request = 1'b0;
    $display("test sharing done");
    // boot length drifts by up to one ext period, hence ranges
    boot(4'h0, 2'h0, 1'b1, 1'b0, n0);
    boot(4'h0, 2'h0, 1'b1, 1'b1, n1);
    boot(4'h0, 2'h1, 1'b1, 1'b0, n2);
    check("rdis", {7'h0, ((n1 - n0) inside {[6:30]})}, 8'h01);
    check("sut", {7'h0, ((n2 - n0) inside {[8:32]})}, 8'h01);
    $display("test startup done");
    wake_request = 1'b1;
    @(negedge clk);
    wake_request = 1'b0;
    check("asleep", {7'h0, core_run}, 8'h00);
    // six ext edges at twelve clk each, plus sync and phase slack
    for (n0 = 0; n0 < 200 && core_run !== 1'b1; n0++) @(negedge clk);
    check("wake", {7'h0, (n0 inside {[56:84]})}, 8'h01);
    $display("test wake done");
    close_out();
  end
endmodule : dynamic_clock_source_switch_test
